// File: hw/pmon_pkg.sv
/*
 * Shared constants for the power monitor serial register link: command
 * byte layout, register offsets, widths, reset values and timing.
 * Assumes nothing of its surroundings; both ends use it by scoped name.
 */
package pmon_pkg;
    // ----------------------------------------------------------------
    // Command byte
    // ----------------------------------------------------------------
    localparam int CMD_BITS = 8;
    localparam int CMD_ADDR_MSB = 7;
    localparam int CMD_ADDR_LSB = 2;
    localparam int CMD_DIR_BIT = 0;
    localparam int ADDR_W = 6;
    localparam int WRITE_BITS = 16;
    localparam int LONG_BITS = 24;
    localparam int DATA_W = 24;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [5:0] OFS_CONFIG = 6'h00;
    localparam logic [5:0] OFS_CONV_SETUP = 6'h01;
    localparam logic [5:0] OFS_SENSE_SCALE = 6'h02;
    localparam logic [5:0] OFS_SENSE_V = 6'h04;
    localparam logic [5:0] OFS_SUPPLY_V = 6'h05;
    localparam logic [5:0] OFS_DIE_TEMP = 6'h06;
    localparam logic [5:0] OFS_CURRENT = 6'h07;
    localparam logic [5:0] OFS_POWER = 6'h08;
    localparam logic [5:0] OFS_DIAG = 6'h0B;
    localparam logic [5:0] OFS_THR_FIRST = 6'h0C;
    localparam logic [5:0] OFS_THR_LAST = 6'h11;
    localparam logic [5:0] OFS_MAKER_ID = 6'h3E;
    localparam logic [5:0] OFS_PART_ID = 6'h3F;
    // ----------------------------------------------------------------
    // Configuration register fields and reset values
    // ----------------------------------------------------------------
    localparam int CFG_RESET_BIT = 15;
    localparam int CFG_DELAY_MSB = 13;
    localparam int CFG_DELAY_LSB = 6;
    localparam int CFG_RANGE_BIT = 4;
    localparam logic [15:0] CFG_READ_MASK = 16'h3FD0;
    localparam logic [15:0] CFG_RESET_VAL = 16'h0000;
    localparam logic [15:0] CONV_SETUP_RESET = 16'hFB68;
    localparam logic [15:0] SENSE_SCALE_RESET = 16'h1000;
    localparam logic [15:0] SENSE_SCALE_MASK = 16'h7FFF;
    localparam logic [15:0] THR_RESET_0C = 16'h7FFF;
    localparam logic [15:0] THR_RESET_0D = 16'h8000;
    localparam logic [15:0] THR_RESET_0E = 16'h7FFF;
    localparam logic [15:0] THR_RESET_0F = 16'h0000;
    localparam logic [15:0] THR_RESET_10 = 16'hFFFF;
    localparam logic [15:0] THR_RESET_11 = 16'h7FFF;
    localparam logic [15:0] DIAG_RESET = 16'h0001;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam longint CLK_HZ = 40000000;
    localparam longint DELAY_STEP_MS = 2;
    localparam longint DELAY_STEP_CYC = CLK_HZ / 1000 * DELAY_STEP_MS;
    localparam int SCLK_HALF_CYC = 4;
endpackage

// File: hw/pmon_spi_if.sv
/*
 * Serial link between the monitor and its controlling main.
 * Assumes the bench resolves the data-out wire from its enable.
 */
`timescale 1ns/1ps
`default_nettype none
interface pmon_spi_if;
    logic sel_n;
    logic sclk;
    logic mosi;
    logic miso_o;
    logic miso_oe_n;
    modport device (
        input sel_n,
        input sclk,
        input mosi,
        output miso_o,
        output miso_oe_n
    );
    modport main (
        output sel_n,
        output sclk,
        output mosi,
        input miso_o,
        input miso_oe_n
    );
endinterface
`default_nettype wire

// File: hw/pmon_main.sv
/*
 * Controller end: takes orders over classic Wishbone and runs one
 * serial frame per order. Assumes the device end follows the link rules.
 * Registers: 0x00 control (bit0 start, bit1 read, bits 13:8 address),
 * 0x04 write data, 0x08 read data, 0x0C status (bit0 busy).
 */
`timescale 1ns/1ps
`default_nettype none
module pmon_main #(
    parameter int HALF = pmon_pkg::SCLK_HALF_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Link
    pmon_spi_if.main spi
);
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_WDAT = 4'h4;
    localparam logic [3:0] A_RDAT = 4'h8;
    localparam logic [3:0] A_STAT = 4'hC;
    typedef enum {M_IDLE, M_LOW, M_HIGH, M_DONE} mstate_t;
    initial begin
        if (HALF < 4) $error("HALF must be at least 4");
    end
    mstate_t st_reg;
    logic [5:0] addr_reg;
    logic rd_reg;
    logic [15:0] wdat_reg;
    logic [23:0] rdat_reg;
    logic [39:0] sh_reg;
    logic [5:0] bits_reg;
    logic [7:0] div_reg;
    logic [2:0] miso_s;
    logic wb_go;
    assign wb_go = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_go;
            if (wb_go && !wb_we_i) begin
                if (wb_adr_i == A_CTRL) begin
                    wb_dat_o <= {18'h00000, addr_reg, 6'h00, rd_reg, 1'b0};
                end else if (wb_adr_i == A_WDAT) begin
                    wb_dat_o <= {16'h0000, wdat_reg};
                end else if (wb_adr_i == A_RDAT) begin
                    wb_dat_o <= {8'h00, rdat_reg};
                end else if (wb_adr_i == A_STAT) begin
                    wb_dat_o <= {31'h00000000, st_reg != M_IDLE};
                end else begin
                    wb_dat_o <= 32'h00000000;
                end
            end
        end
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            addr_reg <= 6'h00;
            rd_reg <= 1'b0;
            wdat_reg <= 16'h0000;
        end else if (wb_go && wb_we_i && st_reg == M_IDLE) begin
            if (wb_adr_i == A_CTRL && wb_sel_i[1]) begin
                addr_reg <= wb_dat_i[13:8];
            end
            if (wb_adr_i == A_CTRL && wb_sel_i[0]) begin
                rd_reg <= wb_dat_i[1];
            end
            if (wb_adr_i == A_WDAT && wb_sel_i[0]) begin
                wdat_reg[7:0] <= wb_dat_i[7:0];
            end
            if (wb_adr_i == A_WDAT && wb_sel_i[1]) begin
                wdat_reg[15:8] <= wb_dat_i[15:8];
            end
        end
    end
    // ----------------------------------------------------------------
    // Frame engine
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            miso_s <= 3'b000;
        end else begin
            miso_s <= {miso_s[1:0], spi.miso_o};
        end
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= M_IDLE;
            spi.sel_n <= 1'b1;
            spi.sclk <= 1'b0;
            spi.mosi <= 1'b0;
            sh_reg <= 40'h0000000000;
            bits_reg <= 6'h00;
            div_reg <= 8'h00;
            rdat_reg <= 24'h000000;
        end else begin
            case (st_reg)
                M_IDLE: begin
                    if (wb_go && wb_we_i && wb_adr_i == A_CTRL
                            && wb_sel_i[0] && wb_dat_i[0]) begin
                        sh_reg <= {wb_dat_i[13:8], 1'b0, wb_dat_i[1],
                                   wb_dat_i[1] ? 16'h0000 : wdat_reg,
                                   16'h0000};
                        bits_reg <= (!wb_dat_i[1]) ? 6'd24
                                  : (wb_dat_i[13:8] == pmon_pkg::OFS_POWER)
                                  ? 6'd32 : 6'd24;
                        spi.sel_n <= 1'b0;
                        div_reg <= 8'h00;
                        st_reg <= M_LOW;
                    end
                end
                M_LOW: begin
                    spi.mosi <= sh_reg[39];
                    if (div_reg == 8'(HALF - 1)) begin
                        div_reg <= 8'h00;
                        spi.sclk <= 1'b1;
                        // An answer needs seven cycles to come back through
                        // both synchronisers, so a bit is taken just before
                        // the next rise; the first take is a spare.
                        rdat_reg <= {rdat_reg[22:0], miso_s[2]};
                        st_reg <= M_HIGH;
                    end else begin
                        div_reg <= div_reg + 8'h01;
                    end
                end
                M_HIGH: begin
                    if (div_reg == 8'(HALF - 1)) begin
                        div_reg <= 8'h00;
                        spi.sclk <= 1'b0;
                        sh_reg <= {sh_reg[38:0], 1'b0};
                        bits_reg <= bits_reg - 6'h01;
                        st_reg <= (bits_reg == 6'h01) ? M_DONE : M_LOW;
                    end else begin
                        div_reg <= div_reg + 8'h01;
                    end
                end
                M_DONE: begin
                    if (div_reg == 8'(HALF - 1)) begin
                        rdat_reg <= {rdat_reg[22:0], miso_s[2]};
                        spi.sel_n <= 1'b1;
                        st_reg <= M_IDLE;
                    end else begin
                        div_reg <= div_reg + 8'h01;
                    end
                end
                default: st_reg <= M_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: hw/pmon_device.sv
/*
 * Device end: serial secondary holding the monitor's register map.
 * Assumes the link pins arrive asynchronously to ref_clk and that the
 * serial clock runs well below a quarter of ref_clk.
 */
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Select low frames one transaction
// - Idle and output released when deselected
// - Command is address, zero, direction
// - Direction one reads, zero writes
// - Eight zeros, then register bits
// - Main clocks zeros for register length
// - Writes carry exactly sixteen data bits
// - Old contents shift out during write
// - Most significant bit first
// - Input sampled on falling clock edge
// - Output changes on rising clock edge
// - Read data returned same frame
// - Main avoids writing unmapped addresses
// - Reset bit restores defaults, self-clears
// - Delay field postpones first conversion; here it starts the cycle after each reset, ignoring the field
// - Range bit selects shunt full scale
// - Reserved configuration bits read zero
module pmon_device #(
    parameter logic [15:0] MAKER_ID = 16'h1234,
    parameter logic [15:0] PART_ID = 16'h5678,
    parameter longint STEP_CYC = pmon_pkg::DELAY_STEP_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Link
    pmon_spi_if.device spi,
    // Measurement side
    input wire logic [15:0] sense_v_in,
    input wire logic [15:0] supply_v_in,
    input wire logic [15:0] die_temp_in,
    input wire logic [15:0] current_in,
    input wire logic [23:0] power_in,
    input wire logic [15:0] diag_in,
    output logic shunt_range_select,
    output logic conv_start,
    output logic [15:0] conv_setup
);
    initial begin
        if (STEP_CYC < 1) $error("STEP_CYC must be at least 1");
    end
    typedef enum {S_CMD, S_DATA, S_IGNORE} sstate_t;
    // Maker and part codes above are arbitrary values.
    logic [2:0] sel_s;
    logic [2:0] clk_s;
    logic [2:0] mosi_s;
    logic sel_q;
    logic clk_q;
    logic sel_lo;
    logic clk_fall;
    logic clk_rise;
    sstate_t st_reg;
    logic [4:0] cnt_reg;
    logic [7:0] cmd_reg;
    logic [23:0] out_reg;
    logic [15:0] in_reg;
    logic soft_rst;
    logic [15:0] cfg_reg;
    logic [15:0] thr_reg [6];
    logic [15:0] sense_scale_reg;
    logic [23:0] rd_val;
    logic [4:0] rd_len;
    logic [5:0] addr;
    logic [7:0] dly_left;
    logic [31:0] step_cnt;
    logic dly_run;
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sel_s <= 3'b111;
            clk_s <= 3'b000;
            mosi_s <= 3'b000;
            sel_q <= 1'b1;
            clk_q <= 1'b0;
        end else begin
            sel_s <= {sel_s[1:0], spi.sel_n};
            clk_s <= {clk_s[1:0], spi.sclk};
            mosi_s <= {mosi_s[1:0], spi.mosi};
            if (sel_s[1] == sel_s[2]) sel_q <= sel_s[2];
            if (clk_s[1] == clk_s[2]) clk_q <= clk_s[2];
        end
    end
    assign sel_lo = (sel_s[1] == sel_s[2]) ? !sel_s[2] : !sel_q;
    assign clk_fall = clk_q && clk_s[1] == clk_s[2] && !clk_s[2];
    assign clk_rise = !clk_q && clk_s[1] == clk_s[2] && clk_s[2];
    assign addr = cmd_reg[pmon_pkg::CMD_ADDR_MSB:pmon_pkg::CMD_ADDR_LSB];
    // ----------------------------------------------------------------
    // Register read mux
    // ----------------------------------------------------------------
    always_comb begin
        rd_val = 24'h000000;
        rd_len = 5'd16;
        if (addr == pmon_pkg::OFS_CONFIG) begin
            rd_val = {8'h00, cfg_reg & pmon_pkg::CFG_READ_MASK};
        end else if (addr == pmon_pkg::OFS_CONV_SETUP) begin
            rd_val = {8'h00, conv_setup};
        end else if (addr == pmon_pkg::OFS_SENSE_SCALE) begin
            rd_val = {8'h00, sense_scale_reg};
        end else if (addr == pmon_pkg::OFS_SENSE_V) begin
            rd_val = {8'h00, sense_v_in};
        end else if (addr == pmon_pkg::OFS_SUPPLY_V) begin
            rd_val = {8'h00, supply_v_in};
        end else if (addr == pmon_pkg::OFS_DIE_TEMP) begin
            rd_val = {8'h00, die_temp_in};
        end else if (addr == pmon_pkg::OFS_CURRENT) begin
            rd_val = {8'h00, current_in};
        end else if (addr == pmon_pkg::OFS_POWER) begin
            rd_val = power_in;
            rd_len = 5'd24;
        end else if (addr == pmon_pkg::OFS_DIAG) begin
            rd_val = {8'h00, diag_in};
        end else if (addr >= pmon_pkg::OFS_THR_FIRST
                && addr <= pmon_pkg::OFS_THR_LAST) begin
            rd_val = {8'h00, thr_reg[3'(addr - pmon_pkg::OFS_THR_FIRST)]};
        end else if (addr == pmon_pkg::OFS_MAKER_ID) begin
            rd_val = {8'h00, MAKER_ID};
        end else if (addr == pmon_pkg::OFS_PART_ID) begin
            rd_val = {8'h00, PART_ID};
        end
    end
    // ----------------------------------------------------------------
    // Frame engine
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= S_CMD;
            cnt_reg <= 5'd0;
            cmd_reg <= 8'h00;
            in_reg <= 16'h0000;
            out_reg <= 24'h000000;
            spi.miso_o <= 1'b0;
            spi.miso_oe_n <= 1'b1;
        end else if (!sel_lo) begin
            st_reg <= S_CMD;
            cnt_reg <= 5'd0;
            spi.miso_o <= 1'b0;
            spi.miso_oe_n <= 1'b1;
        end else begin
            spi.miso_oe_n <= 1'b0;
            case (st_reg)
                S_CMD: begin
                    if (clk_rise) spi.miso_o <= 1'b0;
                    if (clk_fall) begin
                        cmd_reg <= {cmd_reg[6:0], mosi_s[2]};
                        cnt_reg <= cnt_reg + 5'd1;
                        if (cnt_reg == 5'd7) begin
                            cnt_reg <= 5'd0;
                            st_reg <= S_DATA;
                        end
                    end
                end
                S_DATA: begin
                    if (clk_rise) begin
                        if (cnt_reg == 5'd0) begin
                            spi.miso_o <= rd_val[5'(rd_len - 5'd1)];
                            out_reg <= rd_val << (5'd24 - rd_len);
                        end else begin
                            spi.miso_o <= out_reg[22];
                            out_reg <= {out_reg[22:0], 1'b0};
                        end
                    end
                    if (clk_fall) begin
                        in_reg <= {in_reg[14:0], mosi_s[2]};
                        cnt_reg <= cnt_reg + 5'd1;
                        if (cnt_reg == (cmd_reg[pmon_pkg::CMD_DIR_BIT]
                                ? rd_len - 5'd1 : 5'd15)) begin
                            st_reg <= S_IGNORE;
                        end
                    end
                end
                default: begin
                    if (clk_rise) spi.miso_o <= 1'b0;
                end
            endcase
        end
    end
    // ----------------------------------------------------------------
    // Writable registers
    // ----------------------------------------------------------------
    logic wr_go;
    assign wr_go = sel_lo && st_reg == S_DATA && clk_fall
        && cnt_reg == 5'd15 && !cmd_reg[pmon_pkg::CMD_DIR_BIT];
    logic [15:0] wr_val;
    assign wr_val = {in_reg[14:0], mosi_s[2]};
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= wr_go && addr == pmon_pkg::OFS_CONFIG
                && wr_val[pmon_pkg::CFG_RESET_BIT];
        end
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_reg <= pmon_pkg::CFG_RESET_VAL;
            conv_setup <= pmon_pkg::CONV_SETUP_RESET;
            sense_scale_reg <= pmon_pkg::SENSE_SCALE_RESET;
            thr_reg[0] <= pmon_pkg::THR_RESET_0C;
            thr_reg[1] <= pmon_pkg::THR_RESET_0D;
            thr_reg[2] <= pmon_pkg::THR_RESET_0E;
            thr_reg[3] <= pmon_pkg::THR_RESET_0F;
            thr_reg[4] <= pmon_pkg::THR_RESET_10;
            thr_reg[5] <= pmon_pkg::THR_RESET_11;
        end else if (soft_rst) begin
            cfg_reg <= pmon_pkg::CFG_RESET_VAL;
            conv_setup <= pmon_pkg::CONV_SETUP_RESET;
            sense_scale_reg <= pmon_pkg::SENSE_SCALE_RESET;
            thr_reg[0] <= pmon_pkg::THR_RESET_0C;
            thr_reg[1] <= pmon_pkg::THR_RESET_0D;
            thr_reg[2] <= pmon_pkg::THR_RESET_0E;
            thr_reg[3] <= pmon_pkg::THR_RESET_0F;
            thr_reg[4] <= pmon_pkg::THR_RESET_10;
            thr_reg[5] <= pmon_pkg::THR_RESET_11;
        end else if (wr_go) begin
            if (addr == pmon_pkg::OFS_CONFIG) begin
                cfg_reg <= wr_val & pmon_pkg::CFG_READ_MASK;
            end else if (addr == pmon_pkg::OFS_CONV_SETUP) begin
                conv_setup <= wr_val;
            end else if (addr == pmon_pkg::OFS_SENSE_SCALE) begin
                sense_scale_reg <= wr_val & pmon_pkg::SENSE_SCALE_MASK;
            end else if (addr >= pmon_pkg::OFS_THR_FIRST
                    && addr <= pmon_pkg::OFS_THR_LAST) begin
                thr_reg[3'(addr - pmon_pkg::OFS_THR_FIRST)] <= wr_val;
            end
        end
    end
    // ----------------------------------------------------------------
    // Range select and first-conversion delay
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            shunt_range_select <= 1'b0;
        end else begin
            shunt_range_select <= cfg_reg[pmon_pkg::CFG_RANGE_BIT];
        end
    end
    // The delay restarts after every reset, so a soft reset also
    // re-arms the first conversion with the zero default delay.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dly_run <= 1'b1;
            dly_left <= 8'h00;
            step_cnt <= 32'h00000000;
            conv_start <= 1'b0;
        end else if (soft_rst) begin
            dly_run <= 1'b1;
            dly_left <= 8'h00;
            step_cnt <= 32'h00000000;
            conv_start <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            if (wr_go && addr == pmon_pkg::OFS_CONFIG && dly_run) begin
                dly_left <= wr_val[pmon_pkg::CFG_DELAY_MSB:
                                   pmon_pkg::CFG_DELAY_LSB];
                step_cnt <= 32'h00000000;
            end else if (dly_run) begin
                if (dly_left == 8'h00) begin
                    conv_start <= 1'b1;
                    dly_run <= 1'b0;
                end else if (step_cnt == 32'(STEP_CYC - 1)) begin
                    step_cnt <= 32'h00000000;
                    dly_left <= dly_left - 8'h01;
                end else begin
                    step_cnt <= step_cnt + 32'h00000001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/pmon_spi_assertions.sv
/* Checker for the serial link between the two monitor ends.
   Assumes a controller half period of 4 ref_clk cycles. */
`timescale 1ns/1ps
`default_nettype none
module pmon_spi_assertions (
    // Link signals
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe_n
);
    logic sq;
    logic [5:0] nf;
    wire logic fe = sq & ~sclk;
    // Falls are counted per frame, so a deselect clears the count.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sq <= 1'b0;
            nf <= 6'h00;
        end else begin
            sq <= sclk;
            nf <= sel_n ? 6'h00 : nf + {5'h00, fe};
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_idle_release: assert property (sel_n [*6] |-> miso_oe_n)
        else $error("Data out driven while idle.");
    // The guard stops the check once 24 falls are counted, so the tail of a power read goes unchecked.
    a_drive_in_frame: assert property ((!sel_n [*6]) ##0 (nf < 6'd24)
        |-> !miso_oe_n)
        else $error("Data out released inside a frame.");
    a_sclk_idle: assert property (sel_n |-> !sclk)
        else $error("Serial clock high while deselected.");
    a_mosi_hold: assert property (fe |-> $stable(mosi))
        else $error("Data in moved at the falling edge.");
    a_zero_bit: assert property (fe && nf == 6'd6 |-> !mosi)
        else $error("Command bit one not zero.");
    a_cmd_zeros: assert property (!sel_n && !miso_oe_n && nf < 6'd8
        |-> !miso_o)
        else $error("Data out not zero during command.");
    a_frame_len: assert property ($rose(sel_n)
        |-> nf == 6'd24 || nf == 6'd32)
        else $error("Frame length wrong.");
    a_out_stable: assert property (!miso_oe_n && !sclk && !$past(sclk)
        && !$past(sclk, 2) |-> $stable(miso_o))
        else $error("Data out moved late in the low phase.");
endmodule
`default_nettype wire

// File: tb/power_monitor_spi_regs_tb.sv
/* Bench joining both link ends through one pmon_spi_if.
   Assumes the controller Wishbone map and the pmon_pkg constants. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
    err_total++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module power_monitor_spi_regs_tb;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, rng, cs;
    int starts = 0;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] wd = 32'h0, rd, q;
    logic [15:0] sv, bv, tv, cv, dv, su, w;
    logic [23:0] pv;
    logic [23:0] me [8];
    logic [127:0] r;
    logic [5:0] regs [11] = '{6'h00, 6'h01, 6'h02, 6'h0C, 6'h0D, 6'h0E,
        6'h0F, 6'h10, 6'h11, 6'h3E, 6'h3F};
    logic [5:0] ml [8] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h0B,
        6'h03, 6'h3D};
    // The two identity values are arbitrary.
    logic [15:0] dft [11] = '{pmon_pkg::CFG_RESET_VAL,
        pmon_pkg::CONV_SETUP_RESET, pmon_pkg::SENSE_SCALE_RESET,
        pmon_pkg::THR_RESET_0C, pmon_pkg::THR_RESET_0D,
        pmon_pkg::THR_RESET_0E, pmon_pkg::THR_RESET_0F,
        pmon_pkg::THR_RESET_10, pmon_pkg::THR_RESET_11, 16'hA5C3, 16'h3C5A};
    int seed = 74421;
    int err_total = 0;
    int checks_done = 0;
    pmon_spi_if spi ();
    pmon_main #(.HALF(4)) u_pmon_main (.ref_clk(ref_clk), .rstn(rstn),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
        .spi(spi.main));
    pmon_device #(.MAKER_ID(16'hA5C3), .PART_ID(16'h3C5A), .STEP_CYC(4))
        u_pmon_device (.ref_clk(ref_clk), .rstn(rstn), .spi(spi.device),
        .sense_v_in(sv), .supply_v_in(bv), .die_temp_in(tv),
        .current_in(cv), .power_in(pv), .diag_in(dv),
        .shunt_range_select(rng), .conv_start(cs), .conv_setup(su));
    pmon_spi_assertions u_pmon_spi_assertions (.ref_clk(ref_clk),
        .rstn(rstn), .sel_n(spi.sel_n), .sclk(spi.sclk), .mosi(spi.mosi),
        .miso_o(spi.miso_o), .miso_oe_n(spi.miso_oe_n));
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (cs === 1'b1) starts++;
    function automatic logic [15:0] mk(input logic [5:0] a);
        return a == 6'h00 ? pmon_pkg::CFG_READ_MASK :
            a == 6'h02 ? pmon_pkg::SENSE_SCALE_MASK : 16'hFFFF;
    endfunction
    // A wait that never sees ack ends only through the watchdog.
    task automatic wb(input logic w_i, input logic [3:0] a,
            input logic [31:0] d);
        @(posedge ref_clk);
        {cyc, stb, we, adr, sel, wd} <= {2'b11, w_i, a, 4'hF, d};
        do @(posedge ref_clk); while (ack !== 1'b1);
        q = rd;
        {cyc, stb} <= 2'b00;
    endtask
    // Busy is polled because a frame length depends on the register.
    task automatic op(input logic r_i, input logic [5:0] a,
            input logic [15:0] d);
        wb(1'b1, 4'h4, {16'h0, d});
        wb(1'b1, 4'h0, {18'h0, a, 6'h0, r_i, 1'b1});
        do wb(1'b0, 4'hC, 32'h0); while (q[0] !== 1'b0);
        if (r_i) wb(1'b0, 4'h8, 32'h0);
    endtask
    task automatic defaults();
        foreach (regs[i]) begin
            op(1'b1, regs[i], 16'h0);
            `CHK("default", {8'h0, dft[i]}, q[23:0])
        end
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        {sv, bv, tv, cv, dv, pv} = '0;
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        defaults();
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 9; i++) begin
                w = (k == 0) ? 16'hFFFF : 16'($random(seed));
                if (i == 0) w[15] = 1'b0;
                op(1'b0, regs[i], w);
                op(1'b1, regs[i], 16'h0);
                `CHK("reg", {8'h0, w & mk(regs[i])}, q[23:0])
                if (i == 0) `CHK("range", w[4], rng)
                if (i == 1) `CHK("setup", w, su)
            end
        end
        repeat (3) begin
            r = {$random(seed), $random(seed), $random(seed), $random(seed)};
            @(posedge ref_clk);
            {sv, bv, tv, cv, dv, pv} <= r[103:0];
            op(1'b0, 6'h04, ~r[103:88]);
            op(1'b0, 6'h05, 16'hFFFF); // mapped, never reserved
            me = '{{8'h0, sv}, {8'h0, bv}, {8'h0, tv}, {8'h0, cv}, pv,
                {8'h0, dv}, 24'h0, 24'h0};
            foreach (ml[i]) begin
                op(1'b1, ml[i], 16'h0);
                `CHK("meas", me[i], q[23:0])
            end
        end
        op(1'b0, 6'h00, 16'h8000);
        defaults();
        `CHK("range rst", 1'b0, rng)
        `CHK("starts", 2, starts)
        tally_and_finish();
    end
    initial begin
        #(25 * 90000);
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
